// File: hdl/amlp_dev.sv
`timescale 1ns/1ps
`default_nettype none
module amlp_dev #(
  parameter int DEPTH = amlp_pkg::AMLP_MEM_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rstn,
  amlp_if.dev bus,
  input wire logic loader_busy,
  input wire logic [amlp_pkg::AMLP_CARD_ADDR_W-1:0] card_address,
  input wire logic card_read_n,
  output logic load_mode,
  output logic external_attr_read_n,
  output logic [6:0] mem_rd_addr_unused_n,
  output logic [amlp_pkg::AMLP_DATA_W-1:0] config_value
);
  import amlp_pkg::*;

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  logic [7:0] mem_q [DEPTH];
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [6:0] addr_q;
  logic [6:0] addr_d;
  logic wr_prev_q;
  logic wr_prev_d;
  logic armed_q;
  logic armed_d;
  logic wr_fall;
  logic cfg_wr;
  logic entry_ok;
  logic mem_wr;
  logic [6:0] mem_wa;
  logic [7:0] mem_wd;

  function automatic logic in_ext_range(input logic [9:0] a);
    in_ext_range = (a >= AMLP_EXT_ATTR_LO) && (a <= AMLP_EXT_ATTR_HI);
  endfunction

  // ---------------------------------------------
  // write strobe edge
  // ---------------------------------------------
  always_comb begin
    wr_prev_d = bus.write_n;
    wr_fall = wr_prev_q && !bus.write_n;
  end

  // idle level after reset, so no false edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_prev_q <= 1'b1;
    end else begin
      wr_prev_q <= wr_prev_d;
    end
  end

  // ---------------------------------------------
  // configuration and load mode
  // ---------------------------------------------
  always_comb begin
    cfg_wr = wr_fall && !bus.module_select_n && !bus.addr_latch &&
      (bus.reg_addr == AMLP_ADDR_CONFIG) && bus.external_load_enable;
    // entry window: since reset, loader still busy
    entry_ok = armed_q && loader_busy;
    armed_d = entry_ok;
    cfg_d = cfg_q;
    if (cfg_wr) begin
      cfg_d = bus.local_bus_h;
      if (bus.local_bus_h[AMLP_LOAD_BIT] && !entry_ok && !cfg_q[AMLP_LOAD_BIT]) begin
        cfg_d[AMLP_LOAD_BIT] = 1'b0;
      end
      // leaving load mode closes the window until reset
      if (!bus.local_bus_h[AMLP_LOAD_BIT]) begin
        armed_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= AMLP_CONFIG_RST;
      armed_q <= 1'b1;
    end else begin
      cfg_q <= cfg_d;
      armed_q <= armed_d;
    end
  end

  // ---------------------------------------------
  // address phase
  // ---------------------------------------------
  always_comb begin
    addr_d = addr_q;
    if (bus.addr_latch && !bus.attribute_select_n) begin
      addr_d = bus.local_bus_h[6:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      addr_q <= 7'h00;
    end else begin
      addr_q <= addr_d;
    end
  end

  // ---------------------------------------------
  // attribute memory, write only
  // ---------------------------------------------
  always_comb begin
    mem_wr = wr_fall && cfg_q[AMLP_LOAD_BIT] && !bus.attribute_select_n &&
      !bus.addr_latch;
    mem_wa = addr_q;
    mem_wd = bus.local_bus_h;
  end

  // no reset: contents undefined until loaded
  always_ff @(posedge clk_sys) begin
    if (mem_wr) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign load_mode = cfg_q[AMLP_LOAD_BIT];
  assign config_value = cfg_q;
  assign mem_rd_addr_unused_n = 7'h7F;
  // config readable; memory never driven back
  assign bus.local_bus_oe_d = !bus.read_n && !bus.module_select_n &&
    (bus.reg_addr == AMLP_ADDR_CONFIG);
  assign bus.local_bus_d = cfg_q;
  assign external_attr_read_n = !(!card_read_n && in_ext_range(card_address));
endmodule
`default_nettype wire

// File: hdl/amlp_host.sv
`timescale 1ns/1ps
`default_nettype none
module amlp_host #(
  parameter int WAIT_CYC = amlp_pkg::AMLP_WAIT_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  amlp_if.host bus,
  input wire logic enable_load,
  input wire logic start_load,
  input wire logic wr_valid,
  input wire logic [6:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic finish_load,
  output logic wr_ready,
  output logic load_active
);
  import amlp_pkg::*;

  typedef enum logic [2:0] {
    AMLP_IDLE = 3'b000, AMLP_CFG = 3'b001, AMLP_ADR = 3'b010,
    AMLP_DAT = 3'b011, AMLP_WAIT = 3'b100, AMLP_EXIT = 3'b101
  } amlp_state_t;

  amlp_state_t st_q, st_d;
  logic [7:0] bus_q, bus_d;
  logic [7:0] dat_q, dat_d;
  logic [15:0] cnt_q, cnt_d;
  logic [1:0] ph_q, ph_d;
  logic ale_q, ale_d, wr_q, wr_d, ms_q, ms_d, cs_q, cs_d, on_q, on_d, ex_q, ex_d;
  logic waited_q, waited_d;

  always_comb begin
    st_d = st_q;
    bus_d = bus_q;
    dat_d = dat_q;
    cnt_d = cnt_q;
    ph_d = ph_q;
    ale_d = 1'b0;
    wr_d = 1'b1;
    ms_d = 1'b1;
    cs_d = 1'b1;
    on_d = on_q;
    ex_d = enable_load;
    waited_d = waited_q;
    if (cnt_q != 16'h0000) begin
      cnt_d = cnt_q - 16'h0001;
    end
    if (cnt_q == 16'h0001) begin
      waited_d = 1'b1;
    end
    case (st_q)
      AMLP_IDLE: begin
        ph_d = 2'h0;
        if (start_load && !on_q) begin
          st_d = AMLP_CFG;
          bus_d = AMLP_LOAD_ON;
          cnt_d = 16'(WAIT_CYC);
          waited_d = 1'b0;
        end else if (wr_valid && on_q) begin
          st_d = AMLP_ADR;
          bus_d = {1'b0, wr_addr};
          dat_d = wr_data;
        end else if (finish_load && on_q && waited_q) begin
          st_d = AMLP_EXIT;
          bus_d = AMLP_LOAD_OFF;
        end
      end
      AMLP_CFG, AMLP_EXIT: begin
        ms_d = 1'b0;
        wr_d = (ph_q == 2'h1) ? 1'b0 : 1'b1;
        ph_d = ph_q + 2'h1;
        if (ph_q == 2'h2) begin
          // entry write with the enable low is refused
          on_d = (st_q == AMLP_CFG) && ex_q;
          st_d = AMLP_IDLE;
        end
      end
      AMLP_ADR: begin
        cs_d = 1'b0;
        ale_d = (ph_q != 2'h2);
        ph_d = ph_q + 2'h1;
        if (ph_q == 2'h2) begin
          st_d = AMLP_DAT;
          bus_d = dat_q;
          ph_d = 2'h0;
        end
      end
      AMLP_DAT: begin
        cs_d = 1'b0;
        wr_d = (ph_q == 2'h1) ? 1'b0 : 1'b1;
        ph_d = ph_q + 2'h1;
        if (ph_q == 2'h2) begin
          st_d = AMLP_IDLE;
        end
      end
      default: begin
        st_d = AMLP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= AMLP_IDLE;
      bus_q <= 8'h00;
      dat_q <= 8'h00;
      cnt_q <= 16'h0000;
      ph_q <= 2'h0;
      ale_q <= 1'b0;
      wr_q <= 1'b1;
      ms_q <= 1'b1;
      cs_q <= 1'b1;
      on_q <= 1'b0;
      ex_q <= 1'b0;
      waited_q <= 1'b0;
    end else begin
      st_q <= st_d;
      bus_q <= bus_d;
      dat_q <= dat_d;
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      ale_q <= ale_d;
      wr_q <= wr_d;
      ms_q <= ms_d;
      cs_q <= cs_d;
      on_q <= on_d;
      ex_q <= ex_d;
      waited_q <= waited_d;
    end
  end

  assign bus.local_bus_h = bus_q;
  assign bus.reg_addr = AMLP_ADDR_CONFIG;
  assign bus.module_select_n = ms_q;
  assign bus.attribute_select_n = cs_q;
  assign bus.addr_latch = ale_q;
  assign bus.write_n = wr_q;
  assign bus.read_n = 1'b1;
  assign bus.external_load_enable = ex_q;
  assign wr_ready = (st_q == AMLP_IDLE) && on_q;
  assign load_active = on_q;
endmodule
`default_nettype wire

// File: hdl/amlp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface amlp_if;
  import amlp_pkg::*;
  logic [AMLP_DATA_W-1:0] local_bus_h;
  logic [AMLP_DATA_W-1:0] local_bus_d;
  logic local_bus_oe_d;
  logic [AMLP_ADDR_W-1:0] reg_addr;
  logic module_select_n;
  logic attribute_select_n;
  logic addr_latch;
  logic write_n;
  logic read_n;
  logic external_load_enable;
  modport dev (
    input local_bus_h, reg_addr, module_select_n, attribute_select_n, addr_latch,
    input write_n, read_n, external_load_enable,
    output local_bus_d, local_bus_oe_d
  );
  modport host (
    output local_bus_h, reg_addr, module_select_n, attribute_select_n, addr_latch,
    output write_n, read_n, external_load_enable,
    input local_bus_d, local_bus_oe_d
  );
endinterface
`default_nettype wire

// File: hdl/amlp_pkg.sv
`default_nettype none
package amlp_pkg;
  localparam int AMLP_DATA_W = 8;
  localparam int AMLP_ADDR_W = 4;
  localparam int AMLP_CARD_ADDR_W = 10;
  localparam int AMLP_MEM_DEPTH = 128;
  localparam logic [3:0] AMLP_ADDR_CONFIG = 4'h2;
  localparam int AMLP_LOAD_BIT = 7;
  localparam logic [7:0] AMLP_CONFIG_RST = 8'h00;
  localparam logic [7:0] AMLP_MEM_ADDR_MAX = 8'h7F;
  localparam logic [9:0] AMLP_EXT_ATTR_LO = 10'h200;
  localparam logic [9:0] AMLP_EXT_ATTR_HI = 10'h3FF;
  localparam int AMLP_CLK_MHZ = 125;
  // loader wait of 0.6/f_MHz ms, 600 clock cycles as the WAIT_CYC default
  localparam int AMLP_WAIT_CYC = 600;
  localparam logic [7:0] AMLP_LOAD_ON = 8'h80;
  localparam logic [7:0] AMLP_LOAD_OFF = 8'h00;
endpackage
`default_nettype wire

// File: tb/amlp_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module amlp_assertions (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] local_bus_h,
  input wire logic local_bus_oe_d,
  input wire logic module_select_n,
  input wire logic attribute_select_n,
  input wire logic addr_latch,
  input wire logic write_n,
  input wire logic read_n
);
  import amlp_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_no_read_back: assert property (local_bus_oe_d |-> !read_n && attribute_select_n)
    else $error("bus driven outside a read");
  a_no_bus_fight: assert property (!write_n |-> !local_bus_oe_d)
    else $error("device drives bus during write");
  a_write_one_cycle: assert property ($fell(write_n) |=> write_n)
    else $error("write strobe too long");
  a_latch_not_write: assert property (addr_latch |-> write_n)
    else $error("write during address phase");
  a_addr_in_range: assert property (
    addr_latch && !attribute_select_n |-> local_bus_h <= AMLP_MEM_ADDR_MAX)
    else $error("memory address out of range");
  a_data_held: assert property (!write_n |-> $stable(local_bus_h))
    else $error("data moved under write strobe");
  a_config_selected: assert property (!write_n && attribute_select_n |-> !module_select_n)
    else $error("config write without module select");
  a_data_follows: assert property (
    $fell(addr_latch) && !attribute_select_n |-> ##[1:4] !write_n)
    else $error("no data phase after address");
  c_mem_write: cover property ($fell(write_n) && !attribute_select_n);
  c_addr_phase: cover property (addr_latch && !attribute_select_n);
  c_cfg_write: cover property ($fell(write_n) && attribute_select_n);
endmodule
`default_nettype wire

// File: tb/attribute_memory_local_load_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module attribute_memory_local_load_port_tb_top;
  import amlp_pkg::*;
  logic clk_sys = 0, rstn = 0, enable_load = 0, start_load = 0, wr_valid = 0, finish_load = 0;
  logic loader_busy = 1, card_read_n = 1, load_mode, ext_rd_n, wr_ready, load_active;
  logic [6:0] wr_addr = 0;
  logic [7:0] wr_data = 0, config_value;
  logic [9:0] card_address = 0;
  int errors = 0, checks = 0;
  amlp_if bus_if ();
  amlp_dev amlp_dev_inst (.clk_sys(clk_sys), .rstn(rstn), .bus(bus_if), .loader_busy(loader_busy),
    .card_address(card_address), .card_read_n(card_read_n), .load_mode(load_mode),
    .external_attr_read_n(ext_rd_n), .mem_rd_addr_unused_n(), .config_value(config_value));
  amlp_host #(.WAIT_CYC(10)) amlp_host_inst (.clk_sys(clk_sys), .rstn(rstn), .bus(bus_if),
    .enable_load(enable_load), .start_load(start_load), .wr_valid(wr_valid), .wr_addr(wr_addr),
    .wr_data(wr_data), .finish_load(finish_load), .wr_ready(wr_ready), .load_active(load_active));
  amlp_assertions amlp_assertions_inst (.clk_sys(clk_sys), .rstn(rstn),
    .local_bus_h(bus_if.local_bus_h), .local_bus_oe_d(bus_if.local_bus_oe_d),
    .module_select_n(bus_if.module_select_n), .attribute_select_n(bus_if.attribute_select_n),
    .addr_latch(bus_if.addr_latch), .write_n(bus_if.write_n), .read_n(bus_if.read_n));
  initial forever #4 clk_sys = ~clk_sys;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
  endtask
  task automatic wait_lm(input logic exp);
    for (int i = 0; i < 60 && load_mode !== exp; i++) cyc(1);
  endtask
  task automatic mem_write(input logic [6:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wr_addr = a;
    wr_data = d;
    wr_valid = 1;
    while (wr_ready !== 1'b1 && n < 50) begin
      cyc(1);
      n++;
    end
    cyc(1);
    wr_valid = 0;
    chk({7'h00, n < 50}, 8'h01);
    cyc(6);
    chk(amlp_dev_inst.mem_q[a], d);
  endtask
  task automatic t_blocked();
    pulse(start_load);
    cyc(12);
    chk({7'h00, load_mode}, 8'h00);
    chk(config_value, AMLP_CONFIG_RST);
  endtask
  task automatic t_load();
    enable_load = 1;
    cyc(2);
    pulse(start_load);
    wait_lm(1);
    chk({7'h00, load_mode}, 8'h01);
    chk(config_value, AMLP_LOAD_ON);
    mem_write(7'h00, 8'hA5);
    mem_write(7'h7F, 8'h5A);
    chk({7'h00, load_mode}, 8'h01);
    pulse(finish_load);
    wait_lm(0);
    chk({7'h00, load_mode}, 8'h00);
    chk(config_value, AMLP_LOAD_OFF);
  endtask
  task automatic t_noreentry();
    loader_busy = 0;
    pulse(start_load);
    cyc(20);
    chk({7'h00, load_mode}, 8'h00);
    rstn = 0;
    cyc(2);
    rstn = 1;
    cyc(2);
    pulse(start_load);
    cyc(20);
    chk({7'h00, load_mode}, 8'h00);
    chk(config_value, 8'h00);
  endtask
  task automatic t_ext();
    logic [9:0] a [4] = '{10'h1FF, 10'h200, 10'h3FF, 10'h000};
    logic [7:0] e [4] = '{8'h01, 8'h00, 8'h00, 8'h01};
    card_read_n = 0;
    foreach (a[i]) begin
      card_address = a[i];
      cyc(1);
      chk({7'h00, ext_rd_n}, e[i]);
      chk({7'h00, bus_if.local_bus_oe_d}, 8'h00);
    end
    card_read_n = 1;
    cyc(1);
    chk({7'h00, ext_rd_n}, 8'h01);
  endtask
  task automatic t_reset();
    loader_busy = 1;
    rstn = 0;
    cyc(2);
    rstn = 1;
    cyc(2);
    pulse(start_load);
    wait_lm(1);
    chk({7'h00, load_mode}, 8'h01);
    rstn = 0;
    cyc(2);
    chk({7'h00, load_mode}, 8'h00);
    chk(config_value, AMLP_CONFIG_RST);
    rstn = 1;
    cyc(2);
  endtask
  initial begin
    cyc(6);
    rstn = 1;
    cyc(2);
    chk({7'h00, load_mode}, 8'h00);
    t_blocked();
    t_load();
    t_noreentry();
    t_ext();
    t_reset();
    t_load();
    final_report();
  end
  initial begin
    #20000;
    errors++;
    final_report();
  end
endmodule
`default_nettype wire
